// ==== inc/prio_pkg.sv ====
// package: layout, reset values and types of the priority control register
package prio_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] PRIO_CTRL0_ADDR = 4'h0;
  localparam int unsigned TIMER_LSB = 12;
  localparam int unsigned COMPARE_LSB = 8;
  localparam int unsigned CAPTURE_LSB = 4;
  localparam int unsigned EXT_LSB = 0;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [DATA_W-1:0] WRITE_MASK = 16'h7777;
  localparam int unsigned NUM_SRC = 4;

  typedef logic [2:0] level_t;

  // one level per source, index 0 timer, 1 compare, 2 capture, 3 external line
  typedef struct packed {
    level_t ext_line_zero_priority;
    level_t capture_one_priority;
    level_t compare_one_priority;
    level_t timer_one_priority;
  } prio_fields_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// ==== logic/interrupt_priority_reg_bank0.sv ====
// priority control register bank zero: four 3-bit source levels
//
// Contract
// - timer level field at bits 14..12
// - compare level field at bits 10..8
// - capture level field at bits 6..4
// - value 7 highest, nonzero ranks numerically
// - value 1 is lowest active level
// - value 0 disables the source request
//
// Design decisions made here: the register addresses and the plain strobed port.
module interrupt_priority_reg_bank0 import prio_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire reg_req_t req,
  output logic [DATA_W-1:0] rdata,
  input wire logic [NUM_SRC-1:0] src_req,
  output prio_fields_t levels,
  output logic [NUM_SRC-1:0] req_out,
  output level_t req_level
);

  // ==========================================
  // reset release
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      // removal passes two flops so every register leaves reset on the same edge
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ==========================================
  // register
  function automatic logic [DATA_W-1:0] pack_reg(input prio_fields_t f);
    logic [DATA_W-1:0] v;
    v = '0;
    v[TIMER_LSB +: 3] = f.timer_one_priority;
    v[COMPARE_LSB +: 3] = f.compare_one_priority;
    v[CAPTURE_LSB +: 3] = f.capture_one_priority;
    v[EXT_LSB +: 3] = f.ext_line_zero_priority;
    return v;
  endfunction

  prio_fields_t fields_r;
  prio_fields_t fields_nxt;
  wire hit = req.addr == PRIO_CTRL0_ADDR;
  wire wr_hit = req.wr && hit;
  wire rd_hit = req.rd && hit;
  // gap bits are dropped before storage, so they can never read back
  wire [DATA_W-1:0] wmask = req.wdata & WRITE_MASK;

  always_comb begin
    fields_nxt = fields_r;
    if (wr_hit) begin
      fields_nxt.timer_one_priority = wmask[TIMER_LSB +: 3];
      fields_nxt.compare_one_priority = wmask[COMPARE_LSB +: 3];
      fields_nxt.capture_one_priority = wmask[CAPTURE_LSB +: 3];
      fields_nxt.ext_line_zero_priority = wmask[EXT_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fields_r <= {PRIO_RESET, PRIO_RESET, PRIO_RESET, PRIO_RESET};
    end else begin
      fields_r <= fields_nxt;
    end
  end

  // unmapped addresses read zero; unimplemented bits always zero
  wire [DATA_W-1:0] rdata_nxt = rd_hit ? pack_reg(fields_r) : '0;
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // ==========================================
  // gating and ranking
  level_t lvl [NUM_SRC];
  assign lvl[0] = fields_r.timer_one_priority;
  assign lvl[1] = fields_r.compare_one_priority;
  assign lvl[2] = fields_r.capture_one_priority;
  assign lvl[3] = fields_r.ext_line_zero_priority;

  // gating ahead of the output flop: req_out drops a source one cycle after its level is written to 0, together with levels
  logic [NUM_SRC-1:0] gated;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_gate
      assign gated[gi] = src_req[gi] && (lvl[gi] != PRIO_OFF);
    end
  endgenerate

  // highest pending level; a plain numeric compare makes 7 top and 1 bottom
  level_t best;
  always_comb begin
    best = PRIO_OFF;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (gated[i] && (lvl[i] > best)) begin
        best = lvl[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      levels <= {PRIO_RESET, PRIO_RESET, PRIO_RESET, PRIO_RESET};
      req_out <= '0;
      req_level <= PRIO_OFF;
    end else begin
      levels <= fields_r;
      req_out <= gated;
      req_level <= best;
    end
  end

  // ==========================================
  // checks
  a_read_back_zero: assert property (@(posedge clk) disable iff (!rst_n_r)
    ##1 1'b1 |-> ((rdata & ~WRITE_MASK) == '0))
    else $error("unimplemented bits read nonzero");
  a_timer_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    wr_hit |=> fields_r.timer_one_priority == $past(req.wdata[14:12]))
    else $error("timer field not written");
  a_compare_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    wr_hit |=> fields_r.compare_one_priority == $past(req.wdata[10:8]))
    else $error("compare field not written");
  a_capture_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    wr_hit |=> fields_r.capture_one_priority == $past(req.wdata[6:4]))
    else $error("capture field not written");
  a_ext_write_read: assert property (@(posedge clk) disable iff (!rst_n_r)
    wr_hit ##1 (req.rd && hit) |=> rdata[2:0] == $past(req.wdata[2:0], 2))
    else $error("ext field read back wrong");
  a_disabled_silent: assert property (@(posedge clk) disable iff (!rst_n_r)
    (lvl[0] == 3'h0) |=> !req_out[0])
    else $error("disabled timer source requested");
  a_top_level: assert property (@(posedge clk) disable iff (!rst_n_r)
    (gated[1] && lvl[1] == 3'h7) |=> req_level == 3'h7)
    else $error("level 7 not ranked highest");
  a_low_level: assert property (@(posedge clk) disable iff (!rst_n_r)
    (gated == 4'h4 && lvl[2] == 3'h1) |=> req_level == 3'h1)
    else $error("level 1 source not reported");
  a_idle_level: assert property (@(posedge clk) disable iff (!rst_n_r)
    (gated == '0) |=> req_level == 3'h0)
    else $error("level reported with nothing pending");
  a_ext_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    wr_hit |=> fields_r.ext_line_zero_priority == $past(req.wdata[2:0]))
    else $error("ext field not written");
  a_hold_no_write: assert property (@(posedge clk) disable iff (!rst_n_r)
    !wr_hit |=> fields_r == $past(fields_r))
    else $error("register changed without a mapped write");
  a_unmapped_keep: assert property (@(posedge clk) disable iff (!rst_n_r)
    (req.wr && !hit) |=> fields_r == $past(fields_r))
    else $error("unmapped write changed the register");

  // ==========================================
  // checks: reset values, read path and level outputs
  // the first enabled edge still shows the reset copy, so $rose marks it
  a_reset_fields: assert property (@(posedge clk) disable iff (!rst_n_r)
    $rose(rst_n_r) |-> fields_r == {4{PRIO_RESET}})
    else $error("fields not at reset level after reset");
  a_reset_outputs: assert property (@(posedge clk) disable iff (!rst_n_r)
    $rose(rst_n_r) |-> (rdata == '0 && req_out == '0 && req_level == PRIO_OFF))
    else $error("outputs not cleared by reset");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n_r)
    !rd_hit |=> rdata == '0)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (!rst_n_r)
    (req.rd && !hit) |=> rdata == '0)
    else $error("unmapped read returned data");
  a_read_value: assert property (@(posedge clk) disable iff (!rst_n_r)
    rd_hit |=> rdata == {1'b0, $past(fields_r.timer_one_priority), 1'b0, $past(fields_r.compare_one_priority),
      1'b0, $past(fields_r.capture_one_priority), 1'b0, $past(fields_r.ext_line_zero_priority)})
    else $error("read data does not match fields");
  a_levels_follow: assert property (@(posedge clk) disable iff (!rst_n_r)
    1'b1 |=> levels == $past(fields_r))
    else $error("level outputs lag the register");

  // ==========================================
  // checks: per-source gating and ranking
  // a tie between sources is harmless: only the level is reported
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src_chk
      a_gate_off: assert property (@(posedge clk) disable iff (!rst_n_r)
        (lvl[gi] == PRIO_OFF) |=> !req_out[gi])
        else $error("disabled source request passed");
      a_gate_pass: assert property (@(posedge clk) disable iff (!rst_n_r)
        gated[gi] |=> req_out[gi])
        else $error("enabled source request dropped");
      a_rank_floor: assert property (@(posedge clk) disable iff (!rst_n_r)
        gated[gi] |=> req_level >= $past(lvl[gi]))
        else $error("reported level below a pending source");
      a_rank_top: assert property (@(posedge clk) disable iff (!rst_n_r)
        (gated[gi] && lvl[gi] == 3'h7) |=> req_level == 3'h7)
        else $error("level 7 source not reported");
      a_low_alone: assert property (@(posedge clk) disable iff (!rst_n_r)
        (gated == (4'h1 << gi) && lvl[gi] == 3'h1) |=> req_level == 3'h1)
        else $error("lone level 1 source not reported");
    end
  endgenerate
  a_level_pending: assert property (@(posedge clk) disable iff (!rst_n_r)
    (gated != '0) |=> req_level != PRIO_OFF)
    else $error("pending source reported as level zero");
  a_req_idle: assert property (@(posedge clk) disable iff (!rst_n_r)
    (src_req == '0) |=> req_out == '0)
    else $error("request shown with no source pending");

  // ==========================================
  // coverage of the main scenarios
  c_write: cover property (@(posedge clk) disable iff (!rst_n_r) wr_hit);
  c_read: cover property (@(posedge clk) disable iff (!rst_n_r) req.rd && hit);
  c_disabled: cover property (@(posedge clk) disable iff (!rst_n_r) src_req[0] && lvl[0] == 3'h0);
  c_top: cover property (@(posedge clk) disable iff (!rst_n_r) best == 3'h7);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n_r) wr_hit ##1 rd_hit);

endmodule

// ==== tb/interrupt_priority_reg_bank0_tb_top.sv ====
// testbench: register access, gaps, unmapped address and level gating
module interrupt_priority_reg_bank0_tb_top import prio_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_SRC-1:0] src_req = '0;
  prio_fields_t levels;
  logic [NUM_SRC-1:0] req_out;
  level_t req_level;
  logic [15:0] d;
  int num_errors = 0;
  int checked = 0;
  // table: written word, raw requests, expected gated requests, expected level
  logic [15:0] tw [5] = '{16'h7010, 16'h7010, 16'h7010, 16'h2003, 16'h0100};
  logic [3:0] ts [5] = '{4'hf, 4'h4, 4'h2, 4'h9, 4'h3};
  logic [3:0] exp_out [5] = '{4'h5, 4'h4, 4'h0, 4'h9, 4'h2};
  level_t exp_lvl [5] = '{3'h7, 3'h1, 3'h0, 3'h3, 3'h1};

  interrupt_priority_reg_bank0 interrupt_priority_reg_bank0_inst (
    .clk(clk),
    .reset_n(reset_n),
    .req(req),
    .rdata(rdata),
    .src_req(src_req),
    .levels(levels),
    .req_out(req_out),
    .req_level(req_level)
  );

  // ==========================================================
  // clock and helpers
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // both bus tasks are entered just after a rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic close_out();
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("levels_rst", {4'h0, levels}, {4'h0, {4{PRIO_RESET}}});
    @(posedge clk);
    rd(PRIO_CTRL0_ADDR, d);
    check("reg_rst", d, 16'h4444);
    #1 check("rdata_idle", rdata, 16'h0000);
    wr(PRIO_CTRL0_ADDR, 16'hffff);
    rd(PRIO_CTRL0_ADDR, d);
    check("reg_ones", d, 16'h7777);
    wr(4'h1, 16'h0000);
    rd(4'h1, d);
    check("unmapped", d, 16'h0000);
    rd(PRIO_CTRL0_ADDR, d);
    check("reg_kept", d, 16'h7777);
    for (int i = 0; i < 5; i++) begin
      wr(PRIO_CTRL0_ADDR, tw[i]);
      rd(PRIO_CTRL0_ADDR, d);
      check("reg_field", d, tw[i] & WRITE_MASK);
      src_req <= ts[i];
      repeat (4) @(posedge clk);
      #1 check("levels", {4'h0, levels}, {4'h0, tw[i][2:0], tw[i][6:4], tw[i][10:8], tw[i][14:12]});
      check("req_out", {12'h0, req_out}, {12'h0, exp_out[i]});
      check("req_level", {13'h0, req_level}, {13'h0, exp_lvl[i]});
      @(posedge clk);
    end
    // mid-run reset: fields return to level 4 while timer and compare still request
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 check("levels_rerst", {4'h0, levels}, {4'h0, {4{PRIO_RESET}}});
    check("req_out_rerst", {12'h0, req_out}, 16'h0003);
    check("req_level_rerst", {13'h0, req_level}, {13'h0, PRIO_RESET});
    @(posedge clk);
    rd(PRIO_CTRL0_ADDR, d);
    check("reg_rerst", d, 16'h4444);
    close_out();
  end
endmodule
